/* File: rtl/pin_filter_if.sv */
// carrier between the reset pin filter and the flag logic
`timescale 1ns/1ns
interface pin_filter_if;
  logic raw_n;
  logic filtered_low;
  logic rise_event;
  modport filter (input raw_n, output filtered_low, output rise_event);
  modport user (output raw_n, input filtered_low, input rise_event);
endinterface

/* File: rtl/reset_pin_filter.sv */
// glitch filter and synchroniser for the external reset pin
`timescale 1ns/1ns
module reset_pin_filter #(
  parameter int min_cycles = reset_source_pkg::filter_cycles
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // carrier
  pin_filter_if.filter pins
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [7:0] count;
    logic low;
    logic rise;
  } filter_state_type;

  filter_state_type state;
  filter_state_type next_state;

  // elaboration check: count must fit the 8-bit counter
  if (min_cycles < 1 || min_cycles > 250) begin : g_bad_min_cycles
    $error("min_cycles out of range");
  end

  // ---------------------------------------------
  // filter: low must persist more than min_cycles cycles
  // ---------------------------------------------
  always_comb begin
    next_state = state;
    next_state.sync1 = pins.raw_n;
    next_state.sync2 = state.sync1; // RULE12
    next_state.rise = 1'b0;
    if (!state.sync2) begin
      if (state.count < 8'(min_cycles)) begin
        next_state.count = state.count + 8'h01;
      end else begin
        next_state.low = 1'b1; // RULE2
      end
    end else begin
      next_state.count = 8'h00; // short glitch discarded, RULE2
      next_state.low = 1'b0;
      next_state.rise = state.low;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= '0;
      state.sync1 <= 1'b1;
      state.sync2 <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign pins.filtered_low = state.low;
  assign pins.rise_event = state.rise;

  a_glitch_ignored: assert property (@(posedge clock) disable iff (!rst_n)
    state.sync2 |=> !state.low) else $error("filter held low after pin high"); // RULE2
endmodule // reset_pin_filter

/* File: rtl/reset_source_flags.sv */
// reset source flags and system reset generation
// Summary of operation
// RULE1 - low reset pin holds device in reset
// RULE2 - short glitches on reset pin ignored
// RULE3 - pin reset sets external-reset flag
// RULE4 - brown-out sets sticky bit 1
// RULE5 - power-on sets bit 0
// RULE6 - software can set and clear flags
// RULE7 - software flag writes never reset
// RULE8 - config bit one forces watchdog on
// RULE9 - soft reset one cycle, flag bit 6
// RULE10 - watchdog timeout resets, wakes when asleep
// RULE11 - hard trap conflict resets, flag 15
// RULE12 - pin synchronised before flag update
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns
module reset_source_flags (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // reset sources
  input wire logic ext_reset_pin_n,
  input wire logic power_on_detect,
  input wire logic brownout_detect,
  input wire logic soft_reset_req,
  input wire logic wdt_timeout,
  input wire logic cpu_sleeping,
  input wire logic trap_active,
  input wire logic [3:0] trap_active_prio,
  input wire logic trap_new,
  input wire logic [3:0] trap_new_prio,
  input wire logic wdt_config_force_enable,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // outputs
  output logic system_reset,
  output logic wdt_enabled,
  output logic wake_event
);
  typedef struct packed {
    logic [15:0] cause;
    logic [15:0] rdata;
    logic sys_rst;
    logic soft_pend;
    logic wdt_en;
    logic wake;
  } flags_state_type;

  flags_state_type state;
  flags_state_type next_state;
  logic trap_conflict;
  logic ext_low;
  logic ext_rise;

  pin_filter_if pf ();
  assign pf.raw_n = ext_reset_pin_n;
  assign ext_low = pf.filtered_low;
  assign ext_rise = pf.rise_event;

  // ---------------------------------------------
  // pin filter
  // ---------------------------------------------
  reset_pin_filter #(
    .min_cycles(reset_source_pkg::filter_cycles)
  ) u_filter (
    .clock(clock),
    .rst_n(rst_n),
    .pins(pf)
  );

  // hard trap of lower priority during a higher one
  assign trap_conflict = trap_active && trap_new
    && trap_new_prio >= reset_source_pkg::trap_prio_lo
    && trap_active_prio <= reset_source_pkg::trap_prio_hi
    && trap_new_prio < trap_active_prio; // RULE11

  // ---------------------------------------------
  // flag and reset logic
  // ---------------------------------------------
  always_comb begin
    next_state = state;
    next_state.rdata = 16'h0000;
    next_state.wake = 1'b0;
    next_state.soft_pend = 1'b0;
    // software write first so hardware sets win
    if (reg_write && reg_addr == reset_source_pkg::addr_reset_cause) begin
      next_state.cause = reg_wdata & reset_source_pkg::reset_cause_mask; // RULE6 RULE7
    end
    if (ext_low) begin
      next_state.cause[reset_source_pkg::bit_ext_reset] = 1'b1; // RULE3
    end
    if (brownout_detect) begin
      next_state.cause[reset_source_pkg::bit_brownout] = 1'b1; // RULE4
    end
    if (power_on_detect) begin
      next_state.cause[reset_source_pkg::bit_power_on] = 1'b1; // RULE5
    end
    if (soft_reset_req) begin
      next_state.cause[reset_source_pkg::bit_soft_reset] = 1'b1; // RULE9
      next_state.soft_pend = 1'b1;
    end
    if (wdt_timeout && state.wdt_en) begin
      if (cpu_sleeping) begin
        next_state.wake = 1'b1; // RULE10
      end else begin
        next_state.cause[reset_source_pkg::bit_wdt_timeout] = 1'b1; // RULE10
      end
    end
    if (trap_conflict) begin
      next_state.cause[reset_source_pkg::bit_trap_conflict] = 1'b1; // RULE11
    end
    // watchdog enable: config override or soft enable bit
    next_state.wdt_en = wdt_config_force_enable
      || next_state.cause[reset_source_pkg::bit_wdt_soft_enable]; // RULE8
    // system reset from hardware sources only, never from register writes
    next_state.sys_rst = ext_low || brownout_detect || power_on_detect
      || soft_reset_req || trap_conflict
      || (wdt_timeout && state.wdt_en && !cpu_sleeping); // RULE1 RULE7
    if (reg_read) begin
      case (reg_addr)
        reset_source_pkg::addr_reset_cause: next_state.rdata = state.cause;
        reset_source_pkg::addr_reset_ctrl: next_state.rdata = {14'h0000, state.wdt_en, state.sys_rst};
        default: next_state.rdata = 16'h0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= '0;
      state.cause <= reset_source_pkg::reset_cause_init;
      state.sys_rst <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign system_reset = state.sys_rst;
  assign wdt_enabled = state.wdt_en;
  assign wake_event = state.wake;

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  sequence soft_req_seq;
    soft_reset_req && !ext_low && !brownout_detect && !power_on_detect;
  endsequence

  a_pin_holds_reset: assert property (@(posedge clock) disable iff (!rst_n)
    ext_low |=> system_reset) else $error("reset not held for pin"); // RULE1
  a_ext_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
    ext_low |=> state.cause[reset_source_pkg::bit_ext_reset]) else $error("ext flag missing"); // RULE3
  a_brownout_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    state.cause[1] && !(reg_write && reg_addr == 4'h0) |=> state.cause[1])
    else $error("brownout flag lost"); // RULE4
  a_power_on_flag: assert property (@(posedge clock) disable iff (!rst_n)
    power_on_detect |=> state.cause[0]) else $error("power-on flag missing"); // RULE5
  a_soft_write: assert property (@(posedge clock) disable iff (!rst_n)
    reg_write && reg_addr == 4'h0 && !ext_low && !brownout_detect && !power_on_detect
    && !soft_reset_req && !wdt_timeout && !trap_conflict
    |=> state.cause == (reg_wdata & 16'h80f3) && !system_reset)
    else $error("flag write wrong or caused reset"); // RULE6 RULE7
  a_wdt_forced: assert property (@(posedge clock) disable iff (!rst_n)
    wdt_config_force_enable |=> wdt_enabled) else $error("watchdog not forced on"); // RULE8
  a_soft_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
    soft_req_seq ##1 !soft_reset_req && !ext_low && !brownout_detect && !power_on_detect
    && !wdt_timeout && !trap_conflict |=> !system_reset && state.cause[6])
    else $error("soft reset not one cycle"); // RULE9
  a_wdt_sleep_wake: assert property (@(posedge clock) disable iff (!rst_n)
    wdt_timeout && wdt_enabled && cpu_sleeping |=> wake_event)
    else $error("no wake on watchdog in sleep"); // RULE10
  a_trap_reset: assert property (@(posedge clock) disable iff (!rst_n)
    trap_conflict |=> system_reset && state.cause[15]) else $error("trap conflict missed"); // RULE11
endmodule // reset_source_flags

/* File: rtl/reset_source_pkg.sv */
// constants for the reset source flag block
package reset_source_pkg;
  // register map
  localparam logic [3:0] addr_reset_cause = 4'h0;
  localparam logic [3:0] addr_reset_ctrl = 4'h1;
  // reset_cause_control bit positions
  localparam int bit_power_on = 0;
  localparam int bit_brownout = 1;
  localparam int bit_wdt_soft_enable = 5;
  localparam int bit_ext_reset = 7;
  localparam int bit_wdt_timeout = 4;
  localparam int bit_soft_reset = 6;
  localparam int bit_trap_conflict = 15;
  // flags loaded on rst_n reset: power-on set
  localparam logic [15:0] reset_cause_init = 16'h0001;
  // writable bits of reset_cause_control
  localparam logic [15:0] reset_cause_mask = 16'h80f3;
  // timing
  localparam int clock_period_ns = 50;
  localparam int filter_min_ns = 200;
  localparam int filter_cycles = (filter_min_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int soft_reset_cycles = 1;
  // hard trap priority band
  localparam logic [3:0] trap_prio_lo = 4'hd;
  localparam logic [3:0] trap_prio_hi = 4'hf;
endpackage

/* File: test/reset_source_flags_tb.sv */
// self-checking bench for the reset source flag block
`timescale 1ns/1ns
module reset_source_flags_tb;
  logic clock = 1'h0, rst_n = 1'h0, pin_n, sys_rst, wdt_en, wake, seen = 1'h0;
  logic pod = 1'h0, bod = 1'h0, srq = 1'h0, wto = 1'h0, slp = 1'h0, tact = 1'h0;
  logic tnew = 1'h0, force_en = 1'h1, wr_s = 1'h0, rd_s = 1'h0;
  logic [3:0] tap = 4'hf, tnp = 4'hd, addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, rd_val;
  int err_total = 0, n_checks = 0, cycles = 0, model = 0;
  // ----------------------------------------
  // clock, partner, design
  // ----------------------------------------
  always #25 clock = ~clock;
  reset_supervisor_model sup (.clock(clock), .ext_reset_pin_n(pin_n));
  reset_source_flags DUT (.clock(clock), .rst_n(rst_n), .ext_reset_pin_n(pin_n),
    .power_on_detect(pod), .brownout_detect(bod), .soft_reset_req(srq),
    .wdt_timeout(wto), .cpu_sleeping(slp), .trap_active(tact), .trap_active_prio(tap),
    .trap_new(tnew), .trap_new_prio(tnp), .wdt_config_force_enable(force_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s),
    .reg_rdata(rdata), .system_reset(sys_rst), .wdt_enabled(wdt_en), .wake_event(wake));
  // cycle limit and reset monitor
  always @(posedge clock) begin
    cycles++;
    seen <= seen | sys_rst;
    if (cycles == 3000) begin
      err_total++;
      complete_run;
    end
  end
  // compare one value and count it
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  // single-cycle register write
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge clock);
    wr_s <= 1'h0;
  endtask
  // single-cycle read, data taken in the following cycle and compared
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clock);
    rd_s <= 1'h0;
    #1 rd_val = rdata;
    chk("reg_rdata", e, rd_val);
  endtask
  // one-cycle pulse on a reset source, reset expected on the next edge
  task automatic src(input int k, input int pos);
    @(posedge clock);
    case (k)
      0: bod <= 1'h1;
      1: pod <= 1'h1;
      2: srq <= 1'h1;
      3: wto <= 1'h1;
      default: tnew <= 1'h1;
    endcase
    @(posedge clock);
    {bod, pod, srq, wto, tnew} <= 5'h00;
    #1 chk("system_reset", 16'h0001, {15'h0000, sys_rst});
    model = model | (1 << pos);
  endtask
  task automatic complete_run;
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rd_val = $urandom(71065);
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    rd(reset_source_pkg::addr_reset_cause, reset_source_pkg::reset_cause_init);
    rd(4'h9, 16'h0000);
    model = $urandom & reset_source_pkg::reset_cause_mask;
    wr(reset_source_pkg::addr_reset_cause, model[15:0] | 16'h8040);
    model = model | 32'h8040;
    #1 chk("system_reset", 16'h0000, {15'h0000, sys_rst});
    rd(reset_source_pkg::addr_reset_cause, model[15:0]);
    wr(reset_source_pkg::addr_reset_cause, 16'h0000);
    model = 0;
    tact <= 1'h1;
    tnp <= 4'hd + 4'($urandom_range(1, 0));
    src(0, reset_source_pkg::bit_brownout);
    src(1, reset_source_pkg::bit_power_on);
    src(2, reset_source_pkg::bit_soft_reset);
    @(posedge clock);
    #1 chk("system_reset", 16'h0000, {15'h0000, sys_rst});
    src(3, reset_source_pkg::bit_wdt_timeout);
    src(4, reset_source_pkg::bit_trap_conflict);
    tact <= 1'h0;
    rd(reset_source_pkg::addr_reset_cause, model[15:0]);
    repeat (10) @(posedge clock);
    seen = 1'h0;
    sup.hold_low(3);
    repeat (10) @(posedge clock);
    #1 chk("glitch reset", 16'h0000, {15'h0000, seen});
    sup.hold_low(12);
    #1 chk("system_reset", 16'h0001, {15'h0000, sys_rst});
    repeat (8) @(posedge clock);
    model = model | (1 << reset_source_pkg::bit_ext_reset);
    rd(reset_source_pkg::addr_reset_cause, model[15:0]);
    slp <= 1'h1;
    @(posedge clock);
    wto <= 1'h1;
    @(posedge clock);
    wto <= 1'h0;
    #1 chk("wake_event", 16'h0003, {14'h0000, wake, ~sys_rst});
    slp <= 1'h0;
    rd(reset_source_pkg::addr_reset_cause, model[15:0]);
    wr(reset_source_pkg::addr_reset_cause, 16'h0000);
    rd(reset_source_pkg::addr_reset_ctrl, 16'h0002);
    force_en <= 1'h0;
    wr(reset_source_pkg::addr_reset_cause, 16'h0020);
    rd(reset_source_pkg::addr_reset_ctrl, 16'h0002);
    wr(reset_source_pkg::addr_reset_cause, 16'h0000);
    rd(reset_source_pkg::addr_reset_ctrl, 16'h0000);
    complete_run;
  end
endmodule // reset_source_flags_tb

/* File: test/reset_supervisor_model.sv */
// supervisor model that drives the external reset pin
`timescale 1ns/1ns
module reset_supervisor_model (
  // clock
  input wire logic clock,
  // reset pin, driven push-pull at all times
  output logic ext_reset_pin_n
);
  initial ext_reset_pin_n = 1'h1;
  // hold the pin low for a given number of clock edges, then release high
  task automatic hold_low(input int cycles);
    @(posedge clock);
    ext_reset_pin_n <= 1'h0;
    repeat (cycles) @(posedge clock);
    ext_reset_pin_n <= 1'h1;
  endtask
endmodule // reset_supervisor_model
